// File: ztbu_pkg.sv
`default_nettype none
package ztbu_pkg;
  // Branch kinds handled by the unit
  typedef enum logic [2:0] {
    OP_SHORT_BRANCH_IF_ZERO,
    OP_SHORT_BRANCH_IF_NONZERO,
    OP_COMPACT_BRANCH_IF_ZERO,
    OP_COMPACT_BRANCH_IF_NONZERO,
    OP_CALL_IF_NONNEGATIVE_SHORT_SLOT,
    OP_CALL_IF_NEGATIVE_SHORT_SLOT
  } ztbu_op_e;

  // Widths
  localparam int REGISTER_WIDTH = 32;
  localparam int SHORT_OFFSET_WIDTH = 7;
  localparam int LONG_OFFSET_WIDTH = 16;

  // Address increments
  localparam logic [31:0] SHORT_SLOT_INC = 32'h0000_0002;
  localparam logic [31:0] NEXT_WORD_INC = 32'h0000_0004;
  localparam logic [31:0] LINK_INC = 32'h0000_0006;

  // Register numbers
  localparam logic [4:0] LINK_REG = 5'h1f;
  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [4:0] SHORT_SEL_REG0 = 5'h10;
  localparam logic [4:0] SHORT_SEL_REG1 = 5'h11;

  // Values after reset
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [4:0] RESET_REG = 5'h00;

  // Three-bit selector to register number
  function automatic logic [4:0] map_short_sel(input logic [2:0] sel);
    logic [4:0] reg_num;
    reg_num = {2'b00, sel};
    if (sel == 3'h0) begin
      reg_num = SHORT_SEL_REG0;
    end else if (sel == 3'h1) begin
      reg_num = SHORT_SEL_REG1;
    end
    return reg_num;
  endfunction

  // Delay-slot kinds redirect only after the slot retires
  function automatic logic has_slot(input ztbu_op_e op);
    return !(op == OP_COMPACT_BRANCH_IF_ZERO || op == OP_COMPACT_BRANCH_IF_NONZERO);
  endfunction

  // Forms that write the return link
  function automatic logic is_call(input ztbu_op_e op);
    return op == OP_CALL_IF_NONNEGATIVE_SHORT_SLOT || op == OP_CALL_IF_NEGATIVE_SHORT_SLOT;
  endfunction
endpackage
`default_nettype wire

// File: ztbu_eval.sv
`default_nettype none
// Condition and target arithmetic, purely combinational
module ztbu_eval (
  // Branch being resolved
  input wire ztbu_pkg::ztbu_op_e op_in,
  input wire logic [31:0] pc_in,
  input wire logic [15:0] offset_in,
  // Tested register value
  input wire logic [31:0] value_in,
  // Result
  output logic taken_out,
  output logic [31:0] target_out
);
  // Scaled displacements, sign-extended to full width
  logic [31:0] short_disp;
  logic [31:0] long_disp;
  logic value_zero;

  assign short_disp = {{24{offset_in[6]}}, offset_in[6:0], 1'b0};
  assign long_disp = {{15{offset_in[15]}}, offset_in, 1'b0};
  assign value_zero = (value_in == 32'h0000_0000);

  // Pick condition and base address per kind; no fault is ever raised here
  always_comb begin
    taken_out = 1'b0;
    target_out = pc_in;
    case (op_in)
      ztbu_pkg::OP_SHORT_BRANCH_IF_ZERO: begin
        taken_out = value_zero;
        target_out = pc_in + ztbu_pkg::SHORT_SLOT_INC + short_disp;
      end
      ztbu_pkg::OP_SHORT_BRANCH_IF_NONZERO: begin
        taken_out = !value_zero;
        target_out = pc_in + ztbu_pkg::SHORT_SLOT_INC + short_disp;
      end
      ztbu_pkg::OP_COMPACT_BRANCH_IF_ZERO: begin
        taken_out = value_zero;
        target_out = pc_in + ztbu_pkg::NEXT_WORD_INC + long_disp;
      end
      ztbu_pkg::OP_COMPACT_BRANCH_IF_NONZERO: begin
        taken_out = !value_zero;
        target_out = pc_in + ztbu_pkg::NEXT_WORD_INC + long_disp;
      end
      ztbu_pkg::OP_CALL_IF_NONNEGATIVE_SHORT_SLOT: begin
        taken_out = !value_in[31];
        target_out = pc_in + ztbu_pkg::NEXT_WORD_INC + long_disp;
      end
      ztbu_pkg::OP_CALL_IF_NEGATIVE_SHORT_SLOT: begin
        taken_out = value_in[31];
        target_out = pc_in + ztbu_pkg::NEXT_WORD_INC + long_disp;
      end
      default: begin
        taken_out = 1'b0;
        target_out = pc_in;
      end
    endcase
  end
endmodule
`default_nettype wire

// File: ztbu_unit.sv
`default_nettype none
module ztbu_unit (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Branch issue from decode
  input wire logic issue_valid_in,
  input wire ztbu_pkg::ztbu_op_e issue_op_in,
  input wire logic [31:0] issue_pc_in,
  input wire logic [15:0] issue_offset_in,
  input wire logic [4:0] issue_sel_in,
  // Register file read
  input wire logic [31:0] rf_data_in,
  output logic rf_read_out,
  output logic [4:0] rf_addr_out,
  // Delay slot retirement
  input wire logic slot_retired_in,
  // Return link write
  output logic link_we_out,
  output logic [4:0] link_addr_out,
  output logic [31:0] link_data_out,
  // Fetch redirect
  output logic redirect_out,
  output logic [31:0] redirect_pc_out,
  output logic squash_out,
  // Status
  output logic busy_out
);
  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_SLOT} ztbu_state_e;

  ztbu_state_e state; // Current step
  ztbu_state_e next_state; // Step for next edge
  ztbu_pkg::ztbu_op_e op_q; // Branch kind held
  logic [31:0] pc_q; // Branch address held
  logic [15:0] offset_q; // Offset field held
  logic taken_q; // Condition kept across the slot
  logic [31:0] target_q; // Target kept across the slot
  logic [31:0] tested_value; // Register value as seen by the test
  logic eval_taken; // Condition this cycle
  logic [31:0] eval_target; // Target this cycle
  logic issue_take; // Issue accepted this cycle

  assign issue_take = (state == ST_IDLE) && issue_valid_in;

  // Register 0 reads as zero regardless of what the file returns
  assign tested_value = (rf_addr_out == ztbu_pkg::ZERO_REG) ? 32'h0000_0000 : rf_data_in;

  // Arithmetic shared by all kinds
  ztbu_eval u_eval (
    .op_in(op_q),
    .pc_in(pc_q),
    .offset_in(offset_q),
    .value_in(tested_value),
    .taken_out(eval_taken),
    .target_out(eval_target)
  );

  // Step sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (issue_valid_in) begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        // Slot kinds must wait for the slot before redirecting
        next_state = ztbu_pkg::has_slot(op_q) ? ST_SLOT : ST_IDLE;
      end
      ST_SLOT: begin
        if (slot_retired_in) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture issue fields; the decoder holds nothing after handing over
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_q <= ztbu_pkg::OP_SHORT_BRANCH_IF_ZERO;
      pc_q <= ztbu_pkg::RESET_WORD;
      offset_q <= 16'h0000;
    end else if (issue_take) begin
      op_q <= issue_op_in;
      pc_q <= issue_pc_in;
      offset_q <= issue_offset_in;
    end
  end

  // Register file address; short forms use the narrow selector
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rf_read_out <= 1'b0;
      rf_addr_out <= ztbu_pkg::RESET_REG;
    end else begin
      rf_read_out <= issue_take;
      if (issue_take) begin
        if (issue_op_in == ztbu_pkg::OP_SHORT_BRANCH_IF_ZERO ||
            issue_op_in == ztbu_pkg::OP_SHORT_BRANCH_IF_NONZERO) begin
          rf_addr_out <= ztbu_pkg::map_short_sel(issue_sel_in[2:0]);
        end else begin
          rf_addr_out <= issue_sel_in;
        end
      end
    end
  end

  // Keep condition and target for the step after the slot
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      taken_q <= 1'b0;
      target_q <= ztbu_pkg::RESET_WORD;
    end else if (state == ST_READ) begin
      taken_q <= eval_taken;
      target_q <= eval_target;
    end
  end

  // Return link, written whether or not the call is taken
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_we_out <= 1'b0;
      link_addr_out <= ztbu_pkg::RESET_REG;
      link_data_out <= ztbu_pkg::RESET_WORD;
    end else begin
      link_we_out <= (state == ST_READ) && ztbu_pkg::is_call(op_q);
      if (state == ST_READ) begin
        link_addr_out <= ztbu_pkg::LINK_REG;
        link_data_out <= pc_q + ztbu_pkg::LINK_INC;
      end
    end
  end

  // Fetch redirect: compact at once, slot kinds after the slot retires
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      redirect_out <= 1'b0;
      redirect_pc_out <= ztbu_pkg::RESET_WORD;
      squash_out <= 1'b0;
    end else begin
      redirect_out <= 1'b0;
      squash_out <= 1'b0;
      if (state == ST_READ && !ztbu_pkg::has_slot(op_q) && eval_taken) begin
        redirect_out <= 1'b1;
        redirect_pc_out <= eval_target;
        squash_out <= 1'b1;
      end else if (state == ST_SLOT && slot_retired_in && taken_q) begin
        redirect_out <= 1'b1;
        redirect_pc_out <= target_q;
      end
    end
  end

  // Busy from issue until the branch is fully resolved
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (next_state != ST_IDLE);
    end
  end

  // Named steps of a resolution
  sequence s_compact_hit;
    state == ST_READ && !ztbu_pkg::has_slot(op_q) && eval_taken;
  endsequence
  sequence s_slot_eval;
    state == ST_READ && ztbu_pkg::has_slot(op_q);
  endsequence
  sequence s_slot_release;
    state == ST_SLOT && slot_retired_in && taken_q;
  endsequence

  a_compact_target: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_compact_hit |=> redirect_out && squash_out &&
      redirect_pc_out == $past(pc_q) + 32'h0000_0004 +
      {{15{$past(offset_q[15])}}, $past(offset_q), 1'b0})
    else $error("compact redirect wrong");
  a_compact_squash: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    redirect_out && !$past(state == ST_SLOT) |-> squash_out)
    else $error("compact redirect without squash");
  a_slot_no_early: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_slot_eval |=> !redirect_out ##0 (state == ST_SLOT))
    else $error("slot branch redirected early");
  a_slot_release: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    s_slot_release |=> redirect_out && !squash_out && redirect_pc_out == $past(target_q))
    else $error("slot branch not redirected");
  a_slot_wait: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_SLOT && !slot_retired_in |=> !redirect_out && state == ST_SLOT)
    else $error("slot branch left before slot retired");
  a_link_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_READ && ztbu_pkg::is_call(op_q) |=>
      link_we_out && link_addr_out == 5'h1f && link_data_out == $past(pc_q) + 32'h0000_0006)
    else $error("return link not written");
  a_short_map: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    issue_take && issue_op_in == ztbu_pkg::OP_SHORT_BRANCH_IF_NONZERO && issue_sel_in[2:1] == 2'b00
      |=> rf_addr_out == {4'h8, $past(issue_sel_in[0])})
    else $error("short selector mapped wrong");
  a_always_call: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_READ && op_q == ztbu_pkg::OP_CALL_IF_NONNEGATIVE_SHORT_SLOT &&
      rf_addr_out == 5'h00 |-> eval_taken)
    else $error("call on register 0 not taken");
  a_sign_test: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    state == ST_READ && op_q == ztbu_pkg::OP_CALL_IF_NEGATIVE_SHORT_SLOT |->
      eval_taken == tested_value[31])
    else $error("negative call condition wrong");
endmodule
`default_nettype wire

// File: ztbu_rf_model.sv
`default_nettype none
// Register file as the branch unit sees it, with the link write port
module ztbu_rf_model (
  // Clock
  input wire logic clk_in,
  // Read port, combinational
  input wire logic read_in,
  input wire logic [4:0] addr_in,
  output logic [31:0] data_out,
  // Link write port
  input wire logic we_in,
  input wire logic [4:0] waddr_in,
  input wire logic [31:0] wdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contents, loaded by the bench before each branch
  logic [31:0] regs [32];
  // Last value shown on the read data lines
  logic [31:0] last = 32'h0000_0000;
  // Data is only good while a read is requested; otherwise it toggles
  // every cycle, so a unit that samples late sees garbage
  always_comb begin
    if (read_in) begin
      data_out = regs[addr_in];
    end else begin
      data_out = ~last;
    end
  end
  // Track what was shown
  always_ff @(posedge clk_in) begin
    last <= data_out;
  end
  // Return link lands in the register file
  always @(posedge clk_in) begin
    if (we_in) begin
      regs[waddr_in] <= wdata_in;
    end
  end
endmodule
`default_nettype wire

// File: tb_zero_test_branch_unit.sv
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_zero_test_branch_unit;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic issue_valid = 1'b0;
  ztbu_pkg::ztbu_op_e issue_op = ztbu_pkg::OP_SHORT_BRANCH_IF_ZERO;
  logic [31:0] issue_pc = 32'h0000_0000;
  logic [15:0] issue_offset = 16'h0000;
  logic [4:0] issue_sel = 5'h00;
  logic slot_retired = 1'b0;
  // Observed outputs
  logic [31:0] rf_data, link_data, redirect_pc;
  logic rf_read, link_we, redirect, squash, busy;
  logic [4:0] rf_addr, link_addr;
  // Score
  int fails = 0;
  int checked = 0;
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  ztbu_unit DUT (.sys_clk_in(sys_clk), .rstn_in(rstn), .issue_valid_in(issue_valid),
    .issue_op_in(issue_op), .issue_pc_in(issue_pc), .issue_offset_in(issue_offset),
    .issue_sel_in(issue_sel), .rf_data_in(rf_data), .rf_read_out(rf_read),
    .rf_addr_out(rf_addr), .slot_retired_in(slot_retired), .link_we_out(link_we),
    .link_addr_out(link_addr), .link_data_out(link_data), .redirect_out(redirect),
    .redirect_pc_out(redirect_pc), .squash_out(squash), .busy_out(busy));
  ztbu_rf_model model (.clk_in(sys_clk), .read_in(rf_read), .addr_in(rf_addr),
    .data_out(rf_data), .we_in(link_we), .waddr_in(link_addr), .wdata_in(link_data));
  // Verdict and end of run
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One branch end to end, checked against an integer model
  task automatic run(input ztbu_pkg::ztbu_op_e op, input logic [31:0] pc,
                     input logic [15:0] off, input logic [4:0] sel,
                     input logic [31:0] val, input int slow);
    int reg_n;
    int disp;
    logic short_f;
    logic compact_f;
    logic cond;
    logic [31:0] v;
    logic [31:0] tgt;
    short_f = (op == ztbu_pkg::OP_SHORT_BRANCH_IF_ZERO) ||
              (op == ztbu_pkg::OP_SHORT_BRANCH_IF_NONZERO);
    compact_f = (op == ztbu_pkg::OP_COMPACT_BRANCH_IF_ZERO) ||
                (op == ztbu_pkg::OP_COMPACT_BRANCH_IF_NONZERO);
    // Short selector reaches 2..7, 16, 17 only
    reg_n = short_f ? ((sel[2:0] < 3'h2) ? 16 + int'(sel[2:0]) : int'(sel[2:0])) : int'(sel);
    model.regs[reg_n] = val;
    v = (reg_n == 0) ? 32'h0000_0000 : val;
    // Displacement: sign applied to the field, then doubled
    disp = short_f ? int'(off[6:0]) : int'(off);
    if (short_f && disp > 63) disp -= 128;
    if (!short_f && disp > 32767) disp -= 65536;
    tgt = pc + (short_f ? ztbu_pkg::SHORT_SLOT_INC : ztbu_pkg::NEXT_WORD_INC) + 32'(2 * disp);
    case (op)
      ztbu_pkg::OP_SHORT_BRANCH_IF_ZERO, ztbu_pkg::OP_COMPACT_BRANCH_IF_ZERO: cond = (v == 0);
      ztbu_pkg::OP_SHORT_BRANCH_IF_NONZERO, ztbu_pkg::OP_COMPACT_BRANCH_IF_NONZERO: cond = (v != 0);
      ztbu_pkg::OP_CALL_IF_NONNEGATIVE_SHORT_SLOT: cond = !v[31];
      default: cond = v[31];
    endcase
    @(posedge sys_clk);
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_pc <= pc;
    issue_offset <= off;
    issue_sel <= sel;
    @(posedge sys_clk);
    issue_valid <= 1'b0;
    #1;
    `CHK("rf_read", 1'b1, rf_read)
    `CHK("rf_addr", 5'(reg_n), rf_addr)
    @(posedge sys_clk);
    #1;
    `CHK("rf_read pulse end", 1'b0, rf_read)
    if (compact_f) begin
      `CHK("redirect", cond, redirect)
      `CHK("squash", cond, squash)
      `CHK("busy", 1'b0, busy)
      if (cond) `CHK("target", tgt, redirect_pc)
    end else begin
      if (!short_f) begin
        `CHK("link_we", 1'b1, link_we)
        `CHK("link_addr", 5'h1f, link_addr)
        `CHK("link_data", pc + ztbu_pkg::LINK_INC, link_data)
      end else begin
        `CHK("link_we", 1'b0, link_we)
      end
      // The slot has not run yet, so no redirect may show
      // Retirement is driven on the rising edge, never part-way through a cycle
      for (int i = 0; i <= slow; i++) begin
        `CHK("early redirect", 1'b0, redirect)
        `CHK("busy in slot", 1'b1, busy)
        @(posedge sys_clk);
        if (i < slow) #1;
      end
      // The slot holds one plain 16-bit op, never a branch or a return
      slot_retired <= 1'b1;
      @(posedge sys_clk);
      slot_retired <= 1'b0;
      #1;
      `CHK("redirect", cond, redirect)
      `CHK("squash", 1'b0, squash)
      `CHK("busy", 1'b0, busy)
      if (cond) `CHK("target", tgt, redirect_pc)
    end
  endtask
  // Hang guard, sized well past the expected run of under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    conclude();
  end
  // Test sequence
  initial begin
    logic [15:0] offs [3];
    logic [31:0] vals [3];
    ztbu_pkg::ztbu_op_e op;
    offs = '{16'h007f, 16'h8000, 16'h7fff};
    vals = '{32'h0000_0000, 32'h0000_0001, 32'h8000_0000};
    void'($urandom(9));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    // Every kind with zero, positive and negative values, boundary offsets
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        run(ztbu_pkg::ztbu_op_e'(3'(i)), 32'h0000_4000, offs[j], 5'(j + 2), vals[j], j);
      end
    end
    $display("test kinds done");
    // Every short selector code
    for (int s = 0; s < 8; s++) begin
      run(ztbu_pkg::OP_SHORT_BRANCH_IF_NONZERO, 32'h0000_0100, 16'h0040, 5'(s), 32'h0000_0005, 0);
    end
    $display("test selectors done");
    // Call on register 0 is always taken, whatever the bus shows
    run(ztbu_pkg::OP_CALL_IF_NONNEGATIVE_SHORT_SLOT, 32'h0000_2000, 16'hfff0, 5'h00,
        32'hffff_ffff, 1);
    $display("test unconditional call done");
    // Random traffic; register 31 never tested by calls, slots are one 16-bit op
    for (int k = 0; k < 200; k++) begin
      op = ztbu_pkg::ztbu_op_e'(3'($urandom % 6));
      run(op, 32'($urandom) & 32'hffff_fffe, 16'($urandom), 5'($urandom % 31),
          ($urandom % 3 == 0) ? 32'h0000_0000 : 32'($urandom), int'($urandom % 4));
    end
    $display("test random done");
    conclude();
  end
endmodule
`default_nettype wire
